// ==== rtl/debug_trace_readout_counter.sv ====
// Trace memory readout window and valid line counter, APB slave
// Assumes arm, trace enable, alignment and security arrive as synchronous levels
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
`include "trace_readout_regs.svh"

// Summary of operation
// - 20-bit lines read through 16-bit window
// - Qualifying window read advances read pointer
// - Data only unlocked, unsecured, disarmed, enabled
// - Arming locks the memory against reads
// - Aligned word write while disarmed unlocks
// - Misaligned reads give zero, hold; byte writes keep the lock
// - Armed or disabled reads give zero, hold
// - Memory undefined at power-on, kept otherwise
// - Full flag after 64 captured lines
// - Full clears on arm write, power-on
// - Full flag at count bit seven
// - Six-bit tally of valid lines
// - Tally wrap sets full; end mode continues
// - Tally clears on arm write, power-on
// - Reading never decrements the tally
// - Begin mode ends session at 64 lines
// - Full with nonzero tally means overwritten
// - Trace enable required to read memory
// - Position bit selects end or begin
module debug_trace_readout_counter
  import trace_readout_pkg::*;
(
  input  wire logic        REF_CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        SYS_RESET_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic [3:0]  PSTRB_I,
  input  wire logic        ARM_SET_I,
  input  wire logic        SESSION_ACTIVE_I,
  input  wire logic        TRACE_ENABLE_BIT_I,
  input  wire logic        TRIGGER_POSITION_BIT_I,
  input  wire logic        SECURED_I,
  input  wire logic        CAPTURE_VALID_I,
  input  wire logic [19:0] CAPTURE_LINE_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             BUFFER_FULL_FLAG_O,
  output logic             SESSION_END_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0]    rst_sync_q;
  logic          rst_n;

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Inputs grouped
  apb_req_type   req;
  capture_type   cap;

  assign req = '{sel: PSEL_I, enable: PENABLE_I, write: PWRITE_I, addr: PADDR_I,
                 wdata: PWDATA_I, strb: PSTRB_I};
  assign cap = '{valid: CAPTURE_VALID_I, line: CAPTURE_LINE_I};

  function automatic logic [5:0] ptr_inc(input logic [5:0] p);
    ptr_inc = p + 6'd1;
  endfunction : ptr_inc

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [19:0]   mem_q [`DEPTH];
  logic [5:0]    wr_ptr_q;
  logic [5:0]    tally_q;
  logic          full_q;
  logic          locked_q;
  logic [5:0]    rd_line_q;
  logic          rd_half_q;
  logic          end_q;
  bus_state_type bus_q;
  logic [31:0]   prdata_q;
  logic          pready_q;
  logic          pslverr_q;

  logic          access;
  logic          hit_win;
  logic          hit_mis;
  logic          hit_cnt;
  logic          rd_ok;
  logic          win_read;
  logic          unlock_wr;
  logic          capture;
  logic          wrap;
  logic [15:0]   win_data;

  assign access    = req.sel && req.enable && (bus_q == BUS_IDLE);
  assign hit_win   = (req.addr == `TRW_ADDR);
  assign hit_mis   = (req.addr == `TRW_MIS_ADDR);
  assign hit_cnt   = (req.addr == `TLC_ADDR);
  assign rd_ok     = !locked_q && !SECURED_I && !SESSION_ACTIVE_I
                     && TRACE_ENABLE_BIT_I;
  assign win_read  = access && !req.write && hit_win && rd_ok;
  assign unlock_wr = access && req.write && hit_win
                     && (req.strb == `WORD_STRB) && !SESSION_ACTIVE_I;
  assign capture   = cap.valid && SESSION_ACTIVE_I && TRACE_ENABLE_BIT_I
                     && !end_q && !ARM_SET_I;
  assign wrap      = capture && (tally_q == 6'h3F);
  assign win_data  = rd_half_q ? {12'h000, mem_q[rd_line_q][19:16]}
                               : mem_q[rd_line_q][15:0];

  ////////////////////////////////////////////////////////////////////////////
  // Trace memory, no reset so contents survive all but power-on
  always_ff @(posedge REF_CLK_I)
  begin
    if (capture)
      mem_q[wr_ptr_q] <= cap.line;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture position, tally and full flag
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= `TALLY_RESET;
      tally_q  <= `TALLY_RESET;
      full_q   <= 1'b0;
    end
    else if (ARM_SET_I)
    begin
      wr_ptr_q <= `TALLY_RESET;
      tally_q  <= `TALLY_RESET;
      full_q   <= 1'b0;
    end
    else if (capture)
    begin
      wr_ptr_q <= ptr_inc(wr_ptr_q);
      tally_q  <= ptr_inc(tally_q);
      if (wrap)
        full_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Session end in begin alignment
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      end_q <= 1'b0;
    else if (ARM_SET_I)
      end_q <= 1'b0;
    else if (wrap && TRIGGER_POSITION_BIT_I)
      end_q <= 1'b1;
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      SESSION_END_O <= 1'b0;
    else
      SESSION_END_O <= wrap && TRIGGER_POSITION_BIT_I;
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      BUFFER_FULL_FLAG_O <= 1'b0;
    else if (ARM_SET_I)
      BUFFER_FULL_FLAG_O <= 1'b0;
    else
      BUFFER_FULL_FLAG_O <= full_q || wrap;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      locked_q <= 1'b1;
    else if (SYS_RESET_I || ARM_SET_I || SESSION_ACTIVE_I)
      locked_q <= 1'b1;
    else if (unlock_wr)
      locked_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read pointer, two reads per line, low half first
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_line_q <= `TALLY_RESET;
      rd_half_q <= 1'b0;
    end
    else if (SYS_RESET_I)
    begin
      rd_line_q <= `TALLY_RESET;
      rd_half_q <= 1'b0;
    end
    else if (unlock_wr)
    begin
      rd_line_q <= full_q ? wr_ptr_q : `TALLY_RESET;
      rd_half_q <= 1'b0;
    end
    else if (win_read)
    begin
      rd_half_q <= !rd_half_q;
      if (rd_half_q)
        rd_line_q <= ptr_inc(rd_line_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer, one wait state
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      bus_q <= BUS_IDLE;
    else
    begin
      unique case (bus_q)
        BUS_IDLE: if (access) bus_q <= BUS_RESP;
        BUS_RESP: bus_q <= BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= `READ_ZERO;
    end
    else if (access)
    begin
      pready_q  <= 1'b1;
      pslverr_q <= !(hit_win || hit_mis || hit_cnt);
      prdata_q  <= `READ_ZERO;
      if (!req.write && hit_win && rd_ok)
        prdata_q <= {16'h0000, win_data};
      else if (!req.write && hit_cnt)
        prdata_q <= {24'h00_0000, full_q, 1'b0, tally_q};
    end
    else
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  assign PRDATA_O  = prdata_q;
  assign PREADY_O  = pready_q;
  assign PSLVERR_O = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!rst_n);

  logic [6:0] since_arm_q;
  always_ff @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      since_arm_q <= 7'd0;
    else if (ARM_SET_I)
      since_arm_q <= 7'd0;
    else if (capture && since_arm_q != 7'd64)
      since_arm_q <= since_arm_q + 7'd1;
  end

  read_advance_a: assert property (win_read && rd_half_q
    |=> rd_line_q == ptr_inc($past(rd_line_q)))
    else $error("Window read did not advance line");
  zero_bad_a: assert property (access && !req.write && hit_mis
    |=> PRDATA_O == 32'h0000_0000 && $stable(rd_line_q) && $stable(rd_half_q))
    else $error("Misaligned read not zero");
  armed_zero_a: assert property (access && !req.write && hit_win
    && (SESSION_ACTIVE_I || !TRACE_ENABLE_BIT_I)
    |=> PRDATA_O == 32'h0000_0000 && $stable(rd_half_q))
    else $error("Armed read not zero");
  lock_arm_a: assert property (ARM_SET_I |=> locked_q)
    else $error("Arming did not lock");
  unlock_wr_a: assert property ($fell(locked_q)
    |-> $past(unlock_wr))
    else $error("Lock left without unlock");
  full_set_a: assert property (since_arm_q == 7'd64 |-> full_q)
    else $error("Full flag missing after 64 lines");
  full_clr_a: assert property (ARM_SET_I |=> !full_q && tally_q == 6'h00)
    else $error("Arm write did not clear");
  tally_hold_a: assert property (!capture && !ARM_SET_I |=> $stable(tally_q))
    else $error("Tally moved without capture");
  begin_end_a: assert property (wrap && TRIGGER_POSITION_BIT_I
    |=> SESSION_END_O ##1 !capture)
    else $error("Begin mode did not end session");
  end_cont_a: assert property (wrap && !TRIGGER_POSITION_BIT_I
    |=> full_q && tally_q == 6'h00 && !end_q)
    else $error("End mode wrap wrong");
  answer_a: assert property (access |=> PREADY_O ##1 !PREADY_O)
    else $error("Answer timing wrong");
  read_half_a: assert property (win_read && !SYS_RESET_I
    |=> rd_half_q != $past(rd_half_q))
    else $error("Window read did not toggle half");
  read_lock_a: assert property (access && !req.write && hit_win && locked_q
    |=> PRDATA_O == 32'h0000_0000)
    else $error("Locked read not zero");
  secure_zero_a: assert property (access && !req.write && hit_win
    && SECURED_I && !SYS_RESET_I |=> PRDATA_O == 32'h0000_0000 && $stable(rd_line_q))
    else $error("Secured read not zero");
  unlock_set_a: assert property (unlock_wr && !SYS_RESET_I && !ARM_SET_I
    |=> !locked_q)
    else $error("Unlock write did not unlock");
  lock_keep_a: assert property (access && req.write && !unlock_wr
    && !SESSION_ACTIVE_I && !SYS_RESET_I && !ARM_SET_I |=> locked_q == $past(locked_q))
    else $error("Lock moved by other write");
  noen_hold_a: assert property (access && !req.write && hit_win
    && !TRACE_ENABLE_BIT_I && !SYS_RESET_I |=> $stable(rd_line_q) && $stable(rd_half_q))
    else $error("Disabled read moved pointer");
  full_now_a: assert property (wrap |=> full_q)
    else $error("Wrap did not set full");
  full_hold_a: assert property (full_q && !ARM_SET_I |=> full_q)
    else $error("Full flag lost without arm");
  flag_copy_a: assert property (!ARM_SET_I |=> BUFFER_FULL_FLAG_O == full_q)
    else $error("Full flag copy wrong");
  count_read_a: assert property (access && !req.write && hit_cnt
    |=> PRDATA_O == {24'h00_0000, $past(full_q), 1'b0, $past(tally_q)})
    else $error("Count read wrong");
  tally_step_a: assert property (capture |=> tally_q == ptr_inc($past(tally_q)))
    else $error("Tally did not step");
  full_over_a: assert property (capture && full_q
    |=> full_q && wr_ptr_q == ptr_inc($past(wr_ptr_q)))
    else $error("Overwrite did not wrap");
  arm_restart_a: assert property (ARM_SET_I |=> wr_ptr_q == 6'h00 && !end_q)
    else $error("Arm did not restart capture");
  cnt_write_a: assert property (access && req.write && !hit_win
    && !capture && !ARM_SET_I |=> $stable(tally_q) && $stable(full_q))
    else $error("Write changed count");
  slave_err_a: assert property (access && !(hit_win || hit_mis || hit_cnt)
    |=> PSLVERR_O && PRDATA_O == 32'h0000_0000)
    else $error("Unmapped access not refused");
  sys_reset_a: assert property (SYS_RESET_I |=> locked_q && rd_line_q == 6'h00 && !rd_half_q)
    else $error("System reset did not relock");
  end_full_a: assert property (SESSION_END_O |-> full_q && tally_q == 6'h00)
    else $error("Session end without 64 lines");
  low_pad_a: assert property (win_read && !rd_half_q |=> PRDATA_O[31:16] == 16'h0000)
    else $error("Low half not padded");
  high_pad_a: assert property (win_read && rd_half_q |=> PRDATA_O[31:4] == 28'h000_0000)
    else $error("High half not padded");
  end_mode_a: assert property (wrap && !TRIGGER_POSITION_BIT_I |=> !SESSION_END_O)
    else $error("End mode ended session");

  // Cover points
  wrap_c: cover property (wrap && !TRIGGER_POSITION_BIT_I);
  end_c: cover property (SESSION_END_O);
  read_c: cover property (win_read ##[1:20] win_read);
  unlock_c: cover property (unlock_wr);
  full_read_c: cover property (win_read && full_q);

endmodule : debug_trace_readout_counter

// ==== rtl/trace_readout_regs.svh ====
// Offsets, field positions, reset values and counts of the trace readout block
// Assumes inclusion by the block and by the bench only
`ifndef TRACE_READOUT_REGS_SVH
`define TRACE_READOUT_REGS_SVH

// Register indices, byte address is four times the index
`define TRW_INDEX          8'h24
`define TRW_MIS_INDEX      8'h25
`define TLC_INDEX          8'h2A
`define TRW_ADDR           12'h090
`define TRW_MIS_ADDR       12'h094
`define TLC_ADDR           12'h0A8

// Field positions
`define TLC_FULL_BIT       7
`define TLC_TALLY_MSB      5
`define LINE_WIDTH         20
`define WINDOW_WIDTH       16
`define DEPTH              64
`define PTR_WIDTH          6

// Aligned 16-bit lane pattern and reset values
`define WORD_STRB          4'h3
`define TALLY_RESET        6'h00
`define READ_ZERO          32'h0000_0000

`endif

// ==== rtl/trace_readout_pkg.sv ====
// Types of the trace readout block
// Assumes the register header sits beside it
package trace_readout_pkg;

  typedef enum logic [1:0]
  {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } bus_state_type;

  typedef struct packed
  {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0]  strb;
  } apb_req_type;

  typedef struct packed
  {
    logic        valid;
    logic [19:0] line;
  } capture_type;

endpackage : trace_readout_pkg

// ==== sim/tb_top.sv ====
// Bench of the trace readout window and line counter
// Assumes design package and register header on the include path
`timescale 1ns/10ps
`include "trace_readout_regs.svh"
module tb_top
  import trace_readout_pkg::*;
;
  logic        clk, rst_n, srst, psel, pen, pwr, arm, act, ten, tpos, sec, cv;
  logic        rdy, serr, full, send, e;
  logic [11:0] pa;
  logic [31:0] pwd, prd, r;
  logic [3:0]  pst;
  logic [19:0] cl;
  int          mismatches, compares, cycles, ends;

  debug_trace_readout_counter debug_trace_readout_counter_inst (
    .REF_CLK_I(clk), .RESET_N_I(rst_n), .SYS_RESET_I(srst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PSTRB_I(pst),
    .ARM_SET_I(arm), .SESSION_ACTIVE_I(act), .TRACE_ENABLE_BIT_I(ten),
    .TRIGGER_POSITION_BIT_I(tpos), .SECURED_I(sec), .CAPTURE_VALID_I(cv),
    .CAPTURE_LINE_I(cl), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(serr),
    .BUFFER_FULL_FLAG_O(full), .SESSION_END_O(send));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      mismatches++;
      $display("[FAIL] %0t timeout", $time);
      complete_run();
    end
  end

  always @(negedge clk)
    if (send === 1'b1)
      ends++;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [19:0] line_of(input int k);
    line_of = 20'h3_1000 + 20'(k) * 20'h0_4A5B;
  endfunction : line_of

  function automatic logic [31:0] half(input int k, input bit up);
    logic [19:0] l;
    l = line_of(k);
    half = up ? {28'h000_0000, l[19:16]} : {16'h0000, l[15:0]};
  endfunction : half

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [3:0] s);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= 32'h0000_FFFF;
    pst <= s;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rdy !== 1'b1);
    r = prd;
    e = serr;
    chk(n, 2, "ready");
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic rdw(input logic [31:0] exp, input string m);
    apb(1'b0, `TRW_ADDR, 4'h0);
    chk(r, exp, m);
  endtask : rdw

  task automatic cnt(input logic f, input logic [5:0] t);
    apb(1'b0, `TLC_ADDR, 4'h0);
    chk(r, {24'h0, f, 1'b0, t}, "count");
  endtask : cnt

  task automatic capture(input int base, input int n);
    for (int k = 0; k < n; k++)
    begin
      @(posedge clk);
      cv <= 1'b1;
      cl <= line_of(base + k);
    end
    @(posedge clk);
    cv <= 1'b0;
  endtask : capture

  task automatic arm_on();
    @(posedge clk);
    arm <= 1'b1;
    act <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
  endtask : arm_on

  task automatic disarm_unlock();
    @(posedge clk);
    act <= 1'b0;
    apb(1'b1, `TRW_ADDR, `WORD_STRB);
  endtask : disarm_unlock

  task automatic srst_pulse();
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
  endtask : srst_pulse

  task automatic por();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : por

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_basic();
    cnt(1'b0, 6'd0);
    apb(1'b0, 12'h0FC, 4'h0);
    chk({31'h0, e}, 32'h1, "unmapped");
    apb(1'b1, `TLC_ADDR, 4'hF);
    cnt(1'b0, 6'd0);
    arm_on();
    capture(0, 3);
    rdw(0, "armed");
    cnt(1'b0, 6'd3);
    @(posedge clk);
    act <= 1'b0;
    rdw(0, "locked");
    apb(1'b1, `TRW_ADDR, 4'h1);
    rdw(0, "byte unlock");
    disarm_unlock();
    rdw(half(0, 0), "lo0");
    apb(1'b0, `TRW_MIS_ADDR, 4'h0);
    chk(r, 0, "misaligned");
    rdw(half(0, 1), "hi0");
    @(posedge clk);
    ten <= 1'b0;
    rdw(0, "disabled");
    @(posedge clk);
    ten <= 1'b1;
    sec <= 1'b1;
    rdw(0, "secured");
    @(posedge clk);
    sec <= 1'b0;
    rdw(half(1, 0), "lo1");
    rdw(half(1, 1), "hi1");
    cnt(1'b0, 6'd3);
    srst_pulse();
    cnt(1'b0, 6'd3);
    rdw(0, "relocked");
    apb(1'b1, `TRW_ADDR, `WORD_STRB);
    rdw(half(0, 0), "kept");
    $display("test basic done");
  endtask : t_basic

  task automatic t_wrap();
    arm_on();
    capture(100, 66);
    cnt(1'b1, 6'd2);
    @(negedge clk);
    chk({31'h0, full}, 32'h1, "full");
    srst_pulse();
    cnt(1'b1, 6'd2);
    disarm_unlock();
    rdw(half(102, 0), "oldest lo");
    rdw(half(102, 1), "oldest hi");
    $display("test wrap done");
  endtask : t_wrap

  task automatic t_begin();
    @(posedge clk);
    tpos <= 1'b1;
    arm_on();
    cnt(1'b0, 6'd0);
    @(negedge clk);
    chk({31'h0, full}, 32'h0, "armed full");
    ends = 0;
    capture(200, 65);
    cnt(1'b1, 6'd0);
    chk(ends, 1, "session end");
    disarm_unlock();
    rdw(half(200, 0), "first lo");
    $display("test begin done");
  endtask : t_begin

  task automatic t_por();
    por();
    cnt(1'b0, 6'd0);
    @(negedge clk);
    chk({31'h0, full}, 32'h0, "por full");
    $display("test por done");
  endtask : t_por

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  initial
  begin
    {rst_n, srst, psel, pen, pwr, arm, act, sec, cv, tpos, pa, pwd, pst, cl} = '0;
    ten = 1'b1;
    por();
    t_basic();
    t_wrap();
    t_begin();
    t_por();
    complete_run();
  end
endmodule : tb_top
